//--- shared/lpc_defines.svh
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH

// register indices; byte address is index times four
`define LPC_IDX_LPCTL 10'h06E
`define LPC_IDX_PORT_EN 10'h070
`define LPC_IDX_PORT 10'h071
`define LPC_IDX_MISC 10'h060
`define LPC_IDX_STAT 10'h061

// reset values
`define LPC_RST_LPCTL 8'h48
`define LPC_RST_MISC 8'h04

// lowpower_cal_control fields
`define LPC_F_SLEEP_HI 7
`define LPC_F_SLEEP_LO 5
`define LPC_F_WAKE_HI 4
`define LPC_F_WAKE_LO 3
`define LPC_F_TRIG_MODE 1
`define LPC_F_LOWPOWER_CAL_ENABLE 0

// misc control fields
`define LPC_F_BG_EN 0
`define LPC_F_TRIG_SEL 1
`define LPC_F_SOFT_TRIG 2

// status fields
`define LPC_F_STOPPED 0
`define LPC_F_SLEEPING 1
`define LPC_F_SETTLING 2
`define LPC_F_CALIB 3

// port enable field
`define LPC_F_PORT_EN 0

// delay unit is 256 device-clock periods
`define LPC_UNIT_SHIFT 8
`define LPC_VEC_LEN 673

// bus responses
`define LPC_RESP_OKAY 2'h0
`define LPC_RESP_SLVERR 2'h2

`endif

//--- shared/lpc_pkg.sv
package lpc_pkg;
    typedef enum logic [3:0] {
        LPC_OFF = 4'h1,
        LPC_SLEEP = 4'h2,
        LPC_SETTLE = 4'h4,
        LPC_CALIB = 4'h8
    } lpc_state_type;

    typedef logic [41:0] lpc_count_type;
endpackage

//--- shared/lpc_if.sv
`timescale 1ns/1ps
interface lpc_if;
    logic load;
    lpc_pkg::lpc_count_type load_val;
    logic expired;
    logic busy;
    modport ctl (output load, output load_val, input expired, input busy);
    modport tmr (input load, input load_val, output expired, output busy);
endinterface

//--- design/lpc_timer.sv
`timescale 1ns/1ps
module lpc_timer (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    lpc_if.tmr t
);
    // ****************************************
    // down counter
    // ****************************************
    lpc_pkg::lpc_count_type cnt_q;
    logic exp_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= 42'h0;
        end else if (t.load) begin
            cnt_q <= t.load_val;
        end else if (cnt_q != 42'h0) begin
            cnt_q <= cnt_q - 42'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            exp_q <= 1'b0;
        end else begin
            exp_q <= !t.load && (cnt_q == 42'h1);
        end
    end

    assign t.expired = exp_q;
    assign t.busy = (cnt_q != 42'h0);

    // ****************************************
    // checks
    // ****************************************
    property p_tmr_load;
        @(posedge mclk) disable iff (rst)
        t.load |=> (cnt_q == $past(t.load_val));
    endproperty
    a_tmr_load: assert property (p_tmr_load) else $error("timer did not load"); // [R1]

    property p_tmr_expire;
        @(posedge mclk) disable iff (rst)
        !t.load && cnt_q == 42'h1 |=> t.expired;
    endproperty
    a_tmr_expire: assert property (p_tmr_expire) else $error("timer expired late"); // [R4]
endmodule

//--- design/lpc_top.sv
`timescale 1ns/1ps
`include "lpc_defines.svh"
// Behaviour
// [R1] Sleep code 0..7 gives (2^k+1)*256 cycles, k=3,15..33; reset code 2.
// [R2] Sleep countdown acts only when low-power enabled and triggered mode off.
// [R3] Software should choose sleep code 4 or above.
// [R4] Settle code 0..3 gives (2^k+1)*256 cycles, k=3,18,21,24; reset code 1.
// [R5] Settling wait always precedes calibration after wake, both modes.
// [R6] Software should not choose settle code 0.
// [R7] Triggered mode off: sleep lasts the programmed sleep interval.
// [R8] Triggered mode on: core sleeps until active trigger goes low.
// [R9] Low-power calibration off at reset; works only with background enabled.
// [R10] Port enable bit opens the vector port; resets to zero.
// [R11] Each enabled port read returns next vector entry; 673 reads total.
// [R12] Each enabled port write loads next vector entry; 673 writes total.
// [R13] Software accesses the port only while calibration stopped flag is 1.
// [R14] Software completes all 673 accesses of a sequence.
// [R15] Software may stream every word to the port address.
// [R16] Stopped flag follows background halt, or foreground done when background off.
// [R17] Trigger select picks software bit at 0, hardware input at 1.
// [R18] Index clears when port enable set, advances per port access.
module lpc_top #(
    parameter int ADDR_W = 12,
    parameter int VEC_LEN = `LPC_VEC_LEN,
    parameter int SLEEP_K [0:7] = '{3, 15, 18, 21, 24, 27, 30, 33},
    parameter int WAKE_K [0:3] = '{3, 18, 21, 24}
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // calibration engine
    input wire logic hardware_cal_trigger_input,
    input wire logic bg_halted,
    input wire logic fg_finished,
    input wire logic cal_done,
    output logic core_sleep,
    output logic cal_start,
    // engine access to the vector
    input wire logic [9:0] eng_idx,
    output logic [7:0] eng_data
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
        reg_hit = (addr[ADDR_W-1:2] == idx);
    endfunction

    // [R1] [R4] interval length
    function automatic lpc_pkg::lpc_count_type dly_cycles(input int k);
        dly_cycles = ((42'h1 << k) + 42'h1) << `LPC_UNIT_SHIFT;
    endfunction

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] lpctl_q;
    logic [7:0] misc_q;
    logic port_en_q;
    logic [9:0] idx_q;
    logic [7:0] vec_mem [0:VEC_LEN-1];
    lpc_pkg::lpc_state_type state_q;
    logic cal_start_q;
    logic [7:0] eng_data_q;

    logic [2:0] sleep_interval_sel;
    logic [1:0] wake_settle_sel;
    logic triggered_wake_mode;
    logic lowpower_cal_enable;
    logic background_cal_enable;
    logic trigger_source_select;
    logic software_cal_trigger;
    logic active_trig;
    logic lp_active;
    logic cal_stopped;

    assign sleep_interval_sel = lpctl_q[`LPC_F_SLEEP_HI:`LPC_F_SLEEP_LO];
    assign wake_settle_sel = lpctl_q[`LPC_F_WAKE_HI:`LPC_F_WAKE_LO];
    assign triggered_wake_mode = lpctl_q[`LPC_F_TRIG_MODE];
    assign lowpower_cal_enable = lpctl_q[`LPC_F_LOWPOWER_CAL_ENABLE];
    assign background_cal_enable = misc_q[`LPC_F_BG_EN];
    assign trigger_source_select = misc_q[`LPC_F_TRIG_SEL];
    assign software_cal_trigger = misc_q[`LPC_F_SOFT_TRIG];

    // [R17] trigger source
    assign active_trig = trigger_source_select ? hardware_cal_trigger_input : software_cal_trigger;
    // [R9] gated by background enable
    assign lp_active = lowpower_cal_enable && background_cal_enable;
    // [R16] stopped flag
    assign cal_stopped = background_cal_enable ? bg_halted : fg_finished;

    // ****************************************
    // axi4-lite write side
    // ****************************************
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_go;
    logic wr_map;

    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready = !w_held_q;
    assign wr_go = aw_held_q && w_held_q && !bvalid_q;
    assign wr_map = reg_hit(waddr_q, `LPC_IDX_LPCTL) || reg_hit(waddr_q, `LPC_IDX_PORT_EN)
        || reg_hit(waddr_q, `LPC_IDX_PORT) || reg_hit(waddr_q, `LPC_IDX_MISC)
        || reg_hit(waddr_q, `LPC_IDX_STAT);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            waddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `LPC_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_map ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    logic wr_lo;
    logic wr_port;
    logic en_set;
    assign wr_lo = wr_go && wstrb_q[0];
    assign wr_port = wr_lo && port_en_q && reg_hit(waddr_q, `LPC_IDX_PORT);
    assign en_set = wr_lo && reg_hit(waddr_q, `LPC_IDX_PORT_EN) && wdata_q[`LPC_F_PORT_EN];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lpctl_q <= `LPC_RST_LPCTL;
        end else if (wr_lo && reg_hit(waddr_q, `LPC_IDX_LPCTL)) begin
            lpctl_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            misc_q <= `LPC_RST_MISC;
        end else if (wr_lo && reg_hit(waddr_q, `LPC_IDX_MISC)) begin
            misc_q <= {5'h0, wdata_q[2:0]};
        end
    end

    // [R10] port enable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            port_en_q <= 1'b0;
        end else if (wr_lo && reg_hit(waddr_q, `LPC_IDX_PORT_EN)) begin
            port_en_q <= wdata_q[`LPC_F_PORT_EN];
        end
    end

    // ****************************************
    // axi4-lite read side
    // ****************************************
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_go;
    logic rd_port;
    logic [7:0] rd_byte;
    logic rd_map;

    assign s_axi_arready = !rvalid_q;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign rd_port = rd_go && port_en_q && reg_hit(s_axi_araddr, `LPC_IDX_PORT);

    always_comb begin
        rd_byte = 8'h0;
        rd_map = 1'b1;
        if (reg_hit(s_axi_araddr, `LPC_IDX_LPCTL)) begin
            rd_byte = lpctl_q;
        end else if (reg_hit(s_axi_araddr, `LPC_IDX_PORT_EN)) begin
            rd_byte = {7'h0, port_en_q};
        end else if (reg_hit(s_axi_araddr, `LPC_IDX_PORT)) begin
            // [R11] next entry when enabled
            rd_byte = port_en_q ? vec_mem[idx_q] : 8'h0;
        end else if (reg_hit(s_axi_araddr, `LPC_IDX_MISC)) begin
            rd_byte = misc_q;
        end else if (reg_hit(s_axi_araddr, `LPC_IDX_STAT)) begin
            rd_byte = {4'h0, state_q == lpc_pkg::LPC_CALIB, state_q == lpc_pkg::LPC_SETTLE,
                state_q == lpc_pkg::LPC_SLEEP, cal_stopped};
        end else begin
            rd_map = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `LPC_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h0, rd_byte};
            rresp_q <= rd_map ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ****************************************
    // calibration vector
    // ****************************************
    // [R18] index clear and advance
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idx_q <= 10'h0;
        end else if (en_set) begin
            idx_q <= 10'h0;
        end else if (wr_port || rd_port) begin
            idx_q <= (idx_q == 10'(VEC_LEN - 1)) ? 10'h0 : idx_q + 10'h1;
        end
    end

    // [R12] port write loads entry
    always_ff @(posedge mclk) begin
        if (wr_port) begin
            vec_mem[idx_q] <= wdata_q[7:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            eng_data_q <= 8'h0;
        end else if (eng_idx < 10'(VEC_LEN)) begin
            eng_data_q <= vec_mem[eng_idx];
        end
    end

    assign eng_data = eng_data_q;

    // ****************************************
    // low-power scheduler
    // ****************************************
    lpc_if tif ();

    lpc_timer u_timer (
        .mclk(mclk),
        .rst(rst),
        .t(tif.tmr)
    );

    logic go_sleep;
    logic go_settle;
    logic go_calib;

    assign go_sleep = (state_q == lpc_pkg::LPC_OFF && lp_active)
        || (state_q == lpc_pkg::LPC_CALIB && cal_done && lp_active);
    // [R7] [R8] wake cause depends on mode
    assign go_settle = state_q == lpc_pkg::LPC_SLEEP && lp_active
        && (triggered_wake_mode ? !active_trig : tif.expired);
    assign go_calib = state_q == lpc_pkg::LPC_SETTLE && lp_active && tif.expired;

    // [R2] [R4] timer loads for sleep or settle
    always_comb begin
        tif.load = go_sleep || go_settle;
        tif.load_val = go_settle ? dly_cycles(WAKE_K[wake_settle_sel])
            : dly_cycles(SLEEP_K[sleep_interval_sel]);
    end

    // [R5] settle precedes calibration
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= lpc_pkg::LPC_OFF;
        end else if (!lp_active) begin
            state_q <= lpc_pkg::LPC_OFF;
        end else begin
            case (state_q)
                lpc_pkg::LPC_OFF: begin
                    state_q <= lpc_pkg::LPC_SLEEP;
                end
                lpc_pkg::LPC_SLEEP: begin
                    if (go_settle) begin
                        state_q <= lpc_pkg::LPC_SETTLE;
                    end
                end
                lpc_pkg::LPC_SETTLE: begin
                    if (go_calib) begin
                        state_q <= lpc_pkg::LPC_CALIB;
                    end
                end
                lpc_pkg::LPC_CALIB: begin
                    if (cal_done) begin
                        state_q <= lpc_pkg::LPC_SLEEP;
                    end
                end
                default: begin
                    state_q <= lpc_pkg::LPC_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cal_start_q <= 1'b0;
        end else begin
            cal_start_q <= go_calib;
        end
    end

    assign cal_start = cal_start_q;
    assign core_sleep = (state_q == lpc_pkg::LPC_SLEEP);

    // ****************************************
    // checks
    // ****************************************
    property p_sleep_gated;
        @(posedge mclk) disable iff (rst)
        !lp_active |=> state_q == lpc_pkg::LPC_OFF;
    endproperty
    a_sleep_gated: assert property (p_sleep_gated) else $error("scheduler ran while disabled"); // [R9]

    property p_auto_hold;
        @(posedge mclk) disable iff (rst)
        core_sleep && lp_active && !triggered_wake_mode && !tif.expired |=> core_sleep;
    endproperty
    a_auto_hold: assert property (p_auto_hold) else $error("early autonomous wake"); // [R2]

    property p_settle_first;
        @(posedge mclk) disable iff (rst)
        cal_start |-> $past(state_q == lpc_pkg::LPC_SETTLE) && state_q == lpc_pkg::LPC_CALIB;
    endproperty
    a_settle_first: assert property (p_settle_first) else $error("calibration without settle"); // [R5]

    property p_auto_wake;
        @(posedge mclk) disable iff (rst)
        core_sleep && lp_active && !triggered_wake_mode && tif.expired |=> state_q == lpc_pkg::LPC_SETTLE;
    endproperty
    a_auto_wake: assert property (p_auto_wake) else $error("autonomous wake missed"); // [R7]

    property p_trig_wake;
        @(posedge mclk) disable iff (rst)
        core_sleep && lp_active && triggered_wake_mode |=> (core_sleep == $past(active_trig));
    endproperty
    a_trig_wake: assert property (p_trig_wake) else $error("triggered wake wrong"); // [R8]

    property p_trig_src;
        @(posedge mclk) disable iff (rst)
        core_sleep && lp_active && triggered_wake_mode && trigger_source_select && hardware_cal_trigger_input
            |=> core_sleep;
    endproperty
    a_trig_src: assert property (p_trig_src) else $error("wrong trigger source"); // [R17]

    property p_idx_clear;
        @(posedge mclk) disable iff (rst)
        en_set |=> idx_q == 10'h0 && port_en_q;
    endproperty
    a_idx_clear: assert property (p_idx_clear) else $error("index not cleared"); // [R18]

    property p_idx_step;
        @(posedge mclk) disable iff (rst)
        (rd_port || wr_port) && !en_set && idx_q != 10'(VEC_LEN - 1) |=> idx_q == $past(idx_q) + 10'h1;
    endproperty
    a_idx_step: assert property (p_idx_step) else $error("index did not advance"); // [R11]

    property p_stopped;
        @(posedge mclk) disable iff (rst)
        !background_cal_enable |-> cal_stopped == fg_finished;
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped flag wrong"); // [R16]
endmodule

//--- test/lpc_testbench.sv
`timescale 1ns/1ps
`include "lpc_defines.svh"
module testbench;
    localparam int VL = `LPC_VEC_LEN;
    localparam int SK [0:7] = '{0, 1, 2, 3, 4, 5, 6, 7};
    localparam int WK [0:3] = '{0, 1, 2, 3};
    localparam logic [11:0] A_LP = 12'(`LPC_IDX_LPCTL * 4);
    localparam logic [11:0] A_EN = 12'(`LPC_IDX_PORT_EN * 4);
    localparam logic [11:0] A_PORT = 12'(`LPC_IDX_PORT * 4);
    localparam logic [11:0] A_MISC = 12'(`LPC_IDX_MISC * 4);
    localparam logic [11:0] A_STAT = 12'(`LPC_IDX_STAT * 4);
    localparam logic [11:0] A_BAD = 12'h3FC;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, core_sleep, cal_start;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp;
    logic hw_trig = 1'b1, bg_halted = 1'b0, fg_finished = 1'b0;
    logic [9:0] eng_idx = '0;
    logic [7:0] eng_data, rd;
    logic [1:0] rs;
    int n_mismatch = 0, total_checks = 0, s, w;

    lpc_top #(.ADDR_W(12), .VEC_LEN(VL), .SLEEP_K(SK), .WAKE_K(WK)) dut (
        .mclk(mclk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .hardware_cal_trigger_input(hw_trig), .bg_halted(bg_halted), .fg_finished(fg_finished),
        .cal_done(1'b1), .core_sleep(core_sleep), .cal_start(cal_start),
        .eng_idx(eng_idx), .eng_data(eng_data)
    );

    always #12.5 mclk = ~mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic summarize();
        $display("mismatches %0d, checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ******************************
    // bus cycles
    // ******************************
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta, tw;
        ta = 0;
        tw = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge mclk);
            ta = ta | awready;
            tw = tw | wready;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        do @(negedge mclk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge mclk);
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
        logic t;
        t = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!t) begin
            @(negedge mclk);
            t = arready;
            @(posedge mclk);
            if (t) arvalid <= 1'b0;
        end
        do @(negedge mclk); while (rvalid !== 1'b1);
        d = rdata[7:0];
        r = rresp;
        chk(rdata[31:8], 24'h0, "upper read bits");
        @(posedge mclk);
        rready <= 1'b0;
    endtask

    task automatic wc(input logic [11:0] a, input logic [7:0] d);
        wr(a, d, rs);
        chk(rs, `LPC_RESP_OKAY, "write response");
    endtask

    task automatic rc(input logic [11:0] a, input logic [7:0] e, input string msg);
        rdr(a, rd, rs);
        chk({rs, rd}, {`LPC_RESP_OKAY, e}, msg);
    endtask

    // sleep length and settle length of one full cycle
    task automatic phase(output int sl, output int st);
        sl = 0;
        st = 0;
        do @(negedge mclk); while (cal_start !== 1'b1);
        do @(negedge mclk); while (core_sleep !== 1'b1);
        while (core_sleep === 1'b1) begin sl++; @(negedge mclk); end
        while (cal_start !== 1'b1) begin st++; @(negedge mclk); end
        @(posedge mclk);
    endtask

    function automatic logic [7:0] pat(input int i);
        return 8'(i * 37 + (i >> 3));
    endfunction

    initial begin
        repeat (60000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end

    // ******************************
    // test sequence
    // ******************************
    initial begin
        int n;
        logic [7:0] cfg [0:1];
        cfg = '{8'h89, 8'hB1};
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rc(A_LP, `LPC_RST_LPCTL, "control reset");
        rc(A_EN, 8'h00, "port enable reset");
        rc(A_MISC, `LPC_RST_MISC, "misc reset");
        rc(A_PORT, 8'h00, "closed port read");
        rdr(A_BAD, rd, rs);
        chk({rs, rd}, {`LPC_RESP_SLVERR, 8'h00}, "unmapped read");
        wr(A_BAD, 8'h5A, rs);
        chk(rs, `LPC_RESP_SLVERR, "unmapped write");
        fg_finished <= 1'b1;
        rc(A_STAT, 8'h01, "stopped before port use");
        wc(A_EN, 8'h01);
        rc(A_EN, 8'h01, "port enable set");
        for (int i = 0; i < VL; i++) wc(A_PORT, pat(i));
        wc(A_EN, 8'h01);
        for (int i = 0; i < VL; i++) rc(A_PORT, pat(i), "vector read");
        rc(A_PORT, pat(0), "index wraps");
        eng_idx <= 10'd5;
        repeat (2) @(posedge mclk);
        chk(eng_data, pat(5), "engine view");
        wc(A_EN, 8'h00);
        rc(A_PORT, 8'h00, "closed port after use");
        wc(A_MISC, 8'h05);
        bg_halted <= 1'b1;
        rc(A_STAT, 8'h01, "stopped follows halt");
        bg_halted <= 1'b0;
        rc(A_STAT, 8'h00, "stopped clears");
        wc(A_MISC, 8'h04);
        fg_finished <= 1'b1;
        rc(A_STAT, 8'h01, "stopped from foreground");
        wc(A_LP, 8'h89);
        repeat (40) @(posedge mclk);
        chk(core_sleep, 1'b0, "no sleep without background");
        for (int c = 0; c < 2; c++) begin
            wc(A_LP, 8'h88);
            wc(A_MISC, 8'h05);
            wc(A_LP, cfg[c]);
            rc(A_LP, cfg[c], "control readback");
            phase(s, w);
            n = (2 ** SK[cfg[c][7:5]] + 1) * 256;
            chk(s >= n && s <= n + 2, 1'b1, "sleep length");
            n = (2 ** WK[cfg[c][4:3]] + 1) * 256;
            chk(w >= n && w <= n + 3, 1'b1, "settle length");
        end
        wc(A_LP, 8'h88);
        wc(A_MISC, 8'h03);
        hw_trig <= 1'b1;
        wc(A_LP, 8'h8B);
        repeat (3000) @(posedge mclk);
        chk(core_sleep, 1'b1, "held asleep by trigger");
        hw_trig <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(core_sleep, 1'b0, "hardware trigger wakes");
        phase(s, w);
        n = (2 ** WK[1] + 1) * 256;
        chk(w >= n && w <= n + 3, 1'b1, "settle in trigger mode");
        hw_trig <= 1'b1;
        wc(A_MISC, 8'h05);
        hw_trig <= 1'b0;
        repeat (2000) @(posedge mclk);
        chk(core_sleep, 1'b1, "hardware input ignored");
        wc(A_MISC, 8'h01);
        repeat (3) @(posedge mclk);
        chk(core_sleep, 1'b0, "software trigger wakes");
        wc(A_MISC, 8'h04);
        repeat (3) @(posedge mclk);
        chk(core_sleep, 1'b0, "background off stops");
        rc(A_STAT, 8'h01, "scheduler off");
        summarize();
    end
endmodule
